//--- src/irq_standby_pkg.sv
// constants and carrier types for the interrupt and standby controller
// assumes a single 25 MHz cpu-side clock and an active-low async reset
package irq_standby_pkg;
  localparam int NUM_SRC      = 8;
  localparam int NUM_VEC      = 5;
  localparam int ADDR_W       = 13;
  // source bit positions
  localparam int SRC_TICK     = 0;
  localparam int SRC_BOTH     = 1;
  localparam int SRC_PIN_A    = 2;
  localparam int SRC_PIN_B    = 3;
  localparam int SRC_SERIAL   = 4;
  localparam int SRC_TIMER    = 5;
  localparam int SRC_KEY      = 6;
  localparam int SRC_WATCH    = 7;
  localparam logic [NUM_SRC-1:0] VECTORED_MASK = 8'h3f;
  localparam logic [NUM_SRC-1:0] WAKE_IN_STOP  = 8'hfb;
  // vector table entry addresses
  localparam logic [ADDR_W-1:0] VEC_BASE = 13'h0002;
  localparam logic [ADDR_W-1:0] VEC_LAST = 13'h000b;
  localparam logic [ADDR_W-1:0] VEC_STEP = 13'h0002;
  localparam logic [2:0] NO_LEVEL = 3'h7;
  localparam logic [1:0] KEY_W    = 2'h3;

  typedef enum logic [1:0] {
    RUN_STATE  = 2'b00,
    STOP_STATE = 2'b01,
    HALT_STATE = 2'b10
  } mode_type;

  typedef struct packed {
    logic             tick;
    logic             both_pin;
    logic             pin_a;
    logic             pin_b;
    logic             serial_done;
    logic             timer_match;
    logic             key_pin;
    logic [3:0]       key_return;
    logic             watch;
  } src_in_type;

  typedef struct packed {
    logic             main_osc_run;
    logic             cpu_clk_run;
    logic             cpu_exec;
    logic             tick_timer_run;
    logic             serial_run;
    logic             event_timer_run;
    logic             watch_run;
    logic             adc_run;
    logic             pin_a_run;
  } gate_type;
endpackage

//--- src/interrupt_and_standby_control.sv
// interrupt arbitration, flags and standby sequencing
// assumes cpu issues one-cycle strobes and inputs from pins are async
`timescale 1ns/1ps
module interrupt_and_standby_control (
  input  wire logic                                 clk_in,
  input  wire logic                                 rst_n_in,
  input  wire irq_standby_pkg::src_in_type          src_in,
  input  wire logic [irq_standby_pkg::NUM_SRC-1:0]  source_enable_flag_in,
  input  wire logic                                 master_irq_enable_in,
  input  wire logic                                 edge_rise_a_in,
  input  wire logic                                 edge_rise_b_in,
  input  wire logic [irq_standby_pkg::NUM_SRC-1:0]  flag_clear_in,
  input  wire logic                                 ack_in,
  input  wire logic                                 return_in,
  input  wire logic                                 stop_cmd_in,
  input  wire logic                                 halt_cmd_in,
  input  wire logic                                 on_subsystem_clock_in,
  input  wire logic                                 serial_ext_clock_in,
  input  wire logic                                 timer_count_pin_sel_in,
  input  wire logic                                 watch_on_subclk_in,
  input  wire logic [irq_standby_pkg::ADDR_W-1:0]   vector_data_in,
  output logic [irq_standby_pkg::NUM_SRC-1:0]       source_request_flag_out,
  output logic                                      irq_pending_out,
  output logic [irq_standby_pkg::ADDR_W-1:0]        vector_addr_out,
  output logic [irq_standby_pkg::ADDR_W-1:0]        service_addr_out,
  output logic                                      interrupt_status_flag_out,
  output irq_standby_pkg::mode_type                 mode_out,
  output irq_standby_pkg::gate_type                 gate_out
);
  import irq_standby_pkg::*;

  typedef struct packed {
    logic [NUM_SRC-1:0] sync1;
    logic [NUM_SRC-1:0] sync2;
    logic [NUM_SRC-1:0] prev;
    logic [3:0]         key1;
    logic [3:0]         key2;
    logic [3:0]         key_prev;
    logic [NUM_SRC-1:0] flags;
    logic [2:0]         level;
    logic [2:0]         saved_level;
    logic               in_service;
    logic [ADDR_W-1:0]  vec_addr;
    logic [ADDR_W-1:0]  svc_addr;
    mode_type           mode;
  } state_type;

  state_type state_reg;
  state_type state_next;

  logic [NUM_SRC-1:0] raw_pins;
  logic [NUM_SRC-1:0] sets;
  logic [NUM_SRC-1:0] eligible;
  logic [2:0]         win_vec;
  logic               win_ok;
  logic [2:0]         win_order;
  logic [NUM_SRC-1:0] win_clear;

  assign raw_pins = {src_in.watch, src_in.key_pin, src_in.timer_match, src_in.serial_done,
                     src_in.pin_b, src_in.pin_a, src_in.both_pin, src_in.tick};

  // fixed priority, lowest vector first; test sources excluded
  always_comb begin
    eligible  = state_reg.flags & source_enable_flag_in & VECTORED_MASK;
    win_ok    = 1'b0;
    win_vec   = 3'h0;
    win_clear = '0;
    if (eligible[SRC_TICK] || eligible[SRC_BOTH]) begin
      win_ok  = 1'b1;
      win_vec = 3'h0;
      win_clear[SRC_TICK] = eligible[SRC_TICK];
      win_clear[SRC_BOTH] = eligible[SRC_BOTH] & ~eligible[SRC_TICK];
    end else if (eligible[SRC_PIN_A]) begin
      win_ok  = 1'b1;
      win_vec = 3'h1;
      win_clear[SRC_PIN_A] = 1'b1;
    end else if (eligible[SRC_PIN_B]) begin
      win_ok  = 1'b1;
      win_vec = 3'h2;
      win_clear[SRC_PIN_B] = 1'b1;
    end else if (eligible[SRC_SERIAL]) begin
      win_ok  = 1'b1;
      win_vec = 3'h3;
      win_clear[SRC_SERIAL] = 1'b1;
    end else if (eligible[SRC_TIMER]) begin
      win_ok  = 1'b1;
      win_vec = 3'h4;
      win_clear[SRC_TIMER] = 1'b1;
    end
    win_order = win_vec;
  end

  always_comb begin
    state_next = state_reg;
    // two-flop pin synchronisers
    state_next.sync1    = raw_pins;
    state_next.sync2    = state_reg.sync1;
    state_next.prev     = state_reg.sync2;
    state_next.key1     = src_in.key_return;
    state_next.key2     = state_reg.key1;
    state_next.key_prev = state_reg.key2;
    // edge events only
    sets = '0;
    sets[SRC_TICK]   = state_reg.sync2[SRC_TICK] & ~state_reg.prev[SRC_TICK];
    sets[SRC_BOTH]   = state_reg.sync2[SRC_BOTH] ^ state_reg.prev[SRC_BOTH];
    // pin a logic is stopped in standby
    sets[SRC_PIN_A]  = (state_reg.mode == RUN_STATE) &&
                       (edge_rise_a_in ? (state_reg.sync2[SRC_PIN_A] & ~state_reg.prev[SRC_PIN_A])
                                       : (~state_reg.sync2[SRC_PIN_A] & state_reg.prev[SRC_PIN_A]));
    sets[SRC_PIN_B]  = edge_rise_b_in ? (state_reg.sync2[SRC_PIN_B] & ~state_reg.prev[SRC_PIN_B])
                                      : (~state_reg.sync2[SRC_PIN_B] & state_reg.prev[SRC_PIN_B]);
    sets[SRC_SERIAL] = state_reg.sync2[SRC_SERIAL] & ~state_reg.prev[SRC_SERIAL];
    sets[SRC_TIMER]  = state_reg.sync2[SRC_TIMER] & ~state_reg.prev[SRC_TIMER];
    sets[SRC_KEY]    = (state_reg.sync2[SRC_KEY] & ~state_reg.prev[SRC_KEY]) |
                       (|(~state_reg.key2 & state_reg.key_prev));
    sets[SRC_WATCH]  = state_reg.sync2[SRC_WATCH] & ~state_reg.prev[SRC_WATCH];
    // interval timer requests are dropped in stop only; in halt without main clock just its gate is off, not its flag
    if (state_reg.mode == STOP_STATE) begin
      sets[SRC_TICK] = 1'b0;
    end
    // set wins over clear
    state_next.flags = (state_reg.flags & ~flag_clear_in) | sets;
    // acknowledge: nesting only by strictly higher priority
    if (ack_in && win_ok && master_irq_enable_in && state_reg.mode == RUN_STATE &&
        (!state_reg.in_service || win_order < state_reg.level)) begin
      state_next.flags       = ((state_reg.flags & ~flag_clear_in) & ~win_clear) | sets;
      state_next.saved_level = state_reg.level;
      state_next.level       = win_order;
      state_next.in_service  = 1'b1;
      state_next.vec_addr    = VEC_BASE + ADDR_W'(win_vec) * VEC_STEP;
    end else if (return_in) begin
      state_next.level      = state_reg.saved_level;
      state_next.in_service = (state_reg.saved_level != NO_LEVEL);
      state_next.saved_level = NO_LEVEL;
    end
    // start address read from the programmable table
    state_next.svc_addr = vector_data_in;
    // standby sequencing
    case (state_reg.mode)
      RUN_STATE: begin
        if (stop_cmd_in && !on_subsystem_clock_in) begin
          state_next.mode = STOP_STATE;
        end else if (halt_cmd_in) begin
          state_next.mode = HALT_STATE;
        end
      end
      STOP_STATE, HALT_STATE: begin
        // enabled request releases standby
        if (|(state_next.flags & source_enable_flag_in)) begin
          state_next.mode = RUN_STATE;
        end
      end
      default: state_next.mode = RUN_STATE;
    endcase
  end

  // reset clears status flag and mode
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg             <= '0;
      state_reg.level       <= NO_LEVEL;
      state_reg.saved_level <= NO_LEVEL;
      state_reg.vec_addr    <= VEC_BASE;
      state_reg.mode        <= RUN_STATE;
    end else begin
      state_reg <= state_next;
    end
  end

  logic main_osc;
  assign main_osc = (state_reg.mode != STOP_STATE) && !on_subsystem_clock_in;

  always_comb begin
    gate_out.main_osc_run    = state_reg.mode != STOP_STATE;
    gate_out.cpu_clk_run     = state_reg.mode == RUN_STATE;
    gate_out.cpu_exec        = state_reg.mode == RUN_STATE;
    gate_out.tick_timer_run  = (state_reg.mode != STOP_STATE) && main_osc;
    gate_out.serial_run      = serial_ext_clock_in || main_osc;
    gate_out.event_timer_run = timer_count_pin_sel_in || main_osc;
    gate_out.watch_run       = (state_reg.mode != STOP_STATE) || watch_on_subclk_in;
    gate_out.adc_run         = main_osc;
    gate_out.pin_a_run       = state_reg.mode == RUN_STATE;
  end

  assign source_request_flag_out   = state_reg.flags;
  assign irq_pending_out           = win_ok && master_irq_enable_in;
  assign vector_addr_out           = state_reg.vec_addr;
  assign service_addr_out          = state_reg.svc_addr;
  assign interrupt_status_flag_out = state_reg.in_service;
  assign mode_out                  = state_reg.mode;

  chk_stop_from_sub: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (state_reg.mode == RUN_STATE && stop_cmd_in && on_subsystem_clock_in)
      |=> state_reg.mode != STOP_STATE) else $error("stop entered on subsystem clock");
  chk_test_no_vector: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (state_reg.flags & source_enable_flag_in & ~VECTORED_MASK) != '0 && eligible == '0
      |-> !win_ok) else $error("test source vectored");
  chk_ack_needs_ime: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !master_irq_enable_in && !return_in |=> $stable(state_reg.in_service))
    else $error("acknowledged without master enable");
  chk_vector_range: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    vector_addr_out >= VEC_BASE && vector_addr_out < VEC_LAST)
    else $error("vector outside table");
  chk_both_edges: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (state_reg.sync2[SRC_BOTH] != state_reg.prev[SRC_BOTH]) |=> state_reg.flags[SRC_BOTH])
    else $error("both-edge pin missed");
  chk_wake_enabled: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (state_reg.mode != RUN_STATE && |(state_reg.flags & source_enable_flag_in))
      |=> state_reg.mode == RUN_STATE) else $error("standby not released");
  chk_cpu_stopped: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state_reg.mode != RUN_STATE |-> !gate_out.cpu_exec && !gate_out.cpu_clk_run)
    else $error("cpu runs in standby");
  chk_tick_priority: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    eligible[SRC_TICK] |-> win_vec == 3'h0 && win_clear[SRC_TICK])
    else $error("tick lost priority");
  chk_pin_a_idle: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state_reg.mode != RUN_STATE && !flag_clear_in[SRC_PIN_A] |=> 
      state_reg.flags[SRC_PIN_A] == $past(state_reg.flags[SRC_PIN_A]))
    else $error("pin a active in standby");
endmodule // interrupt_and_standby_control

//--- tb/vector_table_model.sv
// far-side model: program memory holding the interrupt vector table
// assumes the controller presents a 13-bit vector address and samples the data a cycle later
`timescale 1ns/1ps
module vector_table_model
(
  input  wire logic [irq_standby_pkg::ADDR_W-1:0] addr_in,
  output logic      [irq_standby_pkg::ADDR_W-1:0] data_out
);
  import irq_standby_pkg::*;
  // each entry differs, so a wrong vector shows as a wrong start address
  always_comb begin
    if (addr_in >= VEC_BASE && addr_in <= VEC_LAST) begin
      data_out = {addr_in[8:0], 4'h5};
    end else begin
      data_out = ~{addr_in[8:0], 4'h5}; // poison outside the table
    end
  end
endmodule // vector_table_model

//--- tb/interrupt_and_standby_control_bench.sv
// self-checking bench: vectored rows in a loop, then priority, masking and standby cases
// assumes the vector table model answers combinationally at the vector address
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin error_cnt++; \
  $display("unexpected at %0t: got %h want %h", $time, (a), (b)); end end
module interrupt_and_standby_control_bench;
  import irq_standby_pkg::*;
  logic               clk_in, rst_n_in, master_irq_enable, ra, rb, ack, ret, stp, hlt, sub, sext, tpin, wsub;
  logic               pend, ist;
  src_in_type         src;
  logic [NUM_SRC-1:0] en, clr, flags;
  logic [ADDR_W-1:0]  vdata, vaddr, saddr;
  mode_type           mode;
  gate_type           gate;
  int                 error_cnt, check_count, r;
  // source index beside the vector it must give
  logic [15:0] rows [6] = '{{3'h0, 13'h0002}, {3'h1, 13'h0002}, {3'h2, 13'h0004},
                            {3'h3, 13'h0006}, {3'h4, 13'h0008}, {3'h5, 13'h000a}};
  interrupt_and_standby_control interrupt_and_standby_control_inst (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .src_in(src), .source_enable_flag_in(en),
    .master_irq_enable_in(master_irq_enable), .edge_rise_a_in(ra), .edge_rise_b_in(rb), .flag_clear_in(clr),
    .ack_in(ack), .return_in(ret), .stop_cmd_in(stp), .halt_cmd_in(hlt),
    .on_subsystem_clock_in(sub), .serial_ext_clock_in(sext), .timer_count_pin_sel_in(tpin),
    .watch_on_subclk_in(wsub), .vector_data_in(vdata), .source_request_flag_out(flags),
    .irq_pending_out(pend), .vector_addr_out(vaddr), .service_addr_out(saddr),
    .interrupt_status_flag_out(ist), .mode_out(mode), .gate_out(gate));
  vector_table_model vector_table_model_inst (.addr_in(vaddr), .data_out(vdata));
  task report_and_stop;
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task raise(input int i, input logic v);
    @(posedge clk_in);
    case (i)
      0: src.tick <= v;
      1: src.both_pin <= v;
      2: src.pin_a <= v;
      3: src.pin_b <= v;
      4: src.serial_done <= v;
      5: src.timer_match <= v;
      6: src.key_pin <= v;
      default: src.watch <= v;
    endcase
  endtask
  // w: 0 acknowledge, 1 return, 2 stop, 3 halt
  task strobe(input int w);
    @(posedge clk_in);
    ack <= (w == 0);
    ret <= (w == 1);
    stp <= (w == 2);
    hlt <= (w == 3);
    @(posedge clk_in);
    {ack, ret, stp, hlt} <= 4'h0;
    #1;
  endtask
  task clear_all;
    @(posedge clk_in);
    clr <= 8'hff;
    @(posedge clk_in);
    clr <= 8'h00;
  endtask
  // bounded: pin events pass a synchroniser, so allow a few edges
  task wait_flag(input int i);
    int k;
    for (k = 0; k < 12; k++) begin
      @(posedge clk_in);
      #1;
      if (flags[i] === 1'b1) break;
    end
    if (k == 12) begin
      error_cnt++;
      report_and_stop;
    end
  endtask
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  initial begin
    rst_n_in = 1'b0;
    src = '0;
    src.key_return = 4'hf;
    en = 8'hff;
    clr = 8'h00;
    {ack, ret, stp, hlt, sub} = 5'h00;
    {master_irq_enable, ra, rb, sext, tpin, wsub} = 6'h3f;
    cyc(1);
    #1;
    `CHK({flags, ist, vaddr, saddr}, {8'h00, 1'b0, 13'h0002, 13'h0000})
    `CHK(mode, RUN_STATE)
    cyc(2);
    rst_n_in <= 1'b1;
    for (r = 0; r < 6; r++) begin
      raise(rows[r][15:13], 1'b1);
      wait_flag(rows[r][15:13]);
      `CHK(pend, 1'b1)
      strobe(0);
      `CHK(vaddr, rows[r][12:0])
      `CHK({ist, flags[rows[r][15:13]]}, 2'b10)
      cyc(1);
      #1;
      `CHK(saddr, {rows[r][8:0], 4'h5})
      strobe(1);
      raise(rows[r][15:13], 1'b0);
      cyc(6);
      #1;
      `CHK(flags[rows[r][15:13]], rows[r][15:13] == 3'h1)
      clear_all;
    end
    // two pending at once, then a lower one refused while nested
    @(posedge clk_in);
    src.pin_a <= 1'b1;
    src.serial_done <= 1'b1;
    wait_flag(4);
    wait_flag(2);
    strobe(0);
    `CHK(vaddr, 13'h0004)
    strobe(0);
    `CHK({vaddr, flags[4]}, {13'h0004, 1'b1})
    strobe(1);
    strobe(0);
    `CHK(vaddr, 13'h0008)
    strobe(1);
    // shared vector: tick served first, both-edge served by the next acknowledge after return
    @(posedge clk_in);
    src.tick <= 1'b1;
    src.both_pin <= 1'b1;
    wait_flag(1);
    wait_flag(0);
    strobe(0);
    `CHK(flags[1:0], 2'b10)
    strobe(0);
    `CHK(flags[1], 1'b1)
    strobe(1);
    strobe(0);
    `CHK({vaddr, flags[1]}, {13'h0002, 1'b0})
    strobe(1);
    clear_all;
    // master and source enables gate acknowledge
    @(posedge clk_in);
    master_irq_enable <= 1'b0;
    raise(3, 1'b1);
    wait_flag(3);
    `CHK(pend, 1'b0)
    strobe(0);
    `CHK({ist, flags[3]}, 2'b01)
    @(posedge clk_in);
    master_irq_enable <= 1'b1;
    en[3] <= 1'b0;
    cyc(1);
    #1;
    `CHK(pend, 1'b0)
    // falling-edge selection on pin b
    @(posedge clk_in);
    en[3] <= 1'b1;
    rb <= 1'b0;
    raise(3, 1'b0);
    cyc(4);
    clear_all;
    raise(3, 1'b1);
    cyc(6);
    #1;
    `CHK(flags[3], 1'b0)
    raise(3, 1'b0);
    wait_flag(3);
    clear_all;
    @(posedge clk_in);
    rb <= 1'b1;
    // test sources set flags but never vector
    src.key_return <= 4'hd;
    wait_flag(6);
    raise(7, 1'b1);
    wait_flag(7);
    `CHK(pend, 1'b0)
    strobe(0);
    `CHK({ist, flags[7:6]}, 3'h3)
    clear_all;
    raise(6, 1'b1);
    wait_flag(6);
    clear_all;
    // standby: stop refused on the subsystem clock
    @(posedge clk_in);
    sub <= 1'b1;
    strobe(2);
    `CHK(mode, RUN_STATE)
    @(posedge clk_in);
    sub <= 1'b0;
    strobe(2);
    `CHK(mode, STOP_STATE)
    `CHK({gate.main_osc_run, gate.cpu_exec, gate.tick_timer_run}, 3'h0)
    `CHK({gate.serial_run, gate.event_timer_run, gate.watch_run}, 3'h7)
    `CHK({gate.adc_run, gate.pin_a_run}, 2'h0)
    raise(2, 1'b0);
    cyc(3);
    raise(2, 1'b1);
    cyc(6);
    #1;
    `CHK({mode, flags[2]}, {STOP_STATE, 1'b0})
    raise(3, 1'b1);
    wait_flag(3);
    cyc(1);
    #1;
    `CHK(mode, RUN_STATE)
    strobe(0);
    `CHK(ist, 1'b1)
    strobe(3);
    `CHK(mode, HALT_STATE)
    `CHK({gate.cpu_clk_run, gate.main_osc_run, gate.watch_run}, 3'h3)
    `CHK({gate.tick_timer_run, gate.adc_run}, 2'h3)
    // reset in standby while in service
    @(posedge clk_in);
    rst_n_in <= 1'b0;
    cyc(1);
    #1;
    `CHK({mode, ist}, {RUN_STATE, 1'b0})
    @(posedge clk_in);
    rst_n_in <= 1'b1;
    cyc(2);
    report_and_stop;
  end
endmodule // interrupt_and_standby_control_bench
